// File: design/pllh_pkg.sv
// constants for the loop-one lock detector and holdover controller
package pllh_pkg;
    // register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] LOCK_CNT_OFS = 8'h04;
    localparam logic [7:0] WINDOW_OFS = 8'h08;
    localparam logic [7:0] MANUAL_DAC_OFS = 8'h0c;
    localparam logic [7:0] STATUS_OFS = 8'h10;
    localparam logic [7:0] TRACK_OFS = 8'h14;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h18;
    localparam logic [7:0] IRQ_CLR_OFS = 8'h1c;
    localparam logic [7:0] IRQ_EN_OFS = 8'h20;
    // control fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_TRACK_BIT = 2;
    localparam int CTRL_MANSEL_BIT = 3;
    localparam int CTRL_INHIBIT_BIT = 4;
    localparam logic [1:0] HO_MODE_EN = 2'h2;
    // status fields
    localparam int ST_LOCK_BIT = 0;
    localparam int ST_HOLD_BIT = 1;
    localparam int ST_REF_BIT = 2;
    // interrupt events
    localparam int EV_LOCK_GAIN = 0;
    localparam int EV_LOCK_LOSS = 1;
    localparam int EV_HO_ENTER = 2;
    localparam int EV_HO_EXIT = 3;
    localparam int EV_N = 4;
    // reset values
    localparam logic [1:0] MODE_RST = 2'h0;
    localparam logic [15:0] LOCK_CNT_RST = 16'h2710;
    localparam logic [7:0] WINDOW_RST = 8'h04;
    localparam logic [9:0] MANUAL_DAC_RST = 10'h200;
    localparam logic [9:0] TRACK_RST = 10'h200;
    // htrans codes
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    typedef enum {ST_LOCKING, ST_HOLDOVER} pllh_state_type;
endpackage : pllh_pkg

// File: design/pllh_ctl.sv
// loop-one lock detector and holdover controller with ahb-lite registers
// Behaviour
// - lock time scales with threshold times phase-detector period
// - lock flag rises after threshold consecutive in-window detector cycles
// - lock flag falls on the first detector cycle with phase error outside the window
// - with inhibit clear, lock loss enters holdover
// - in holdover, a valid reference exits holdover and relocking resumes
// - holdover mode field equal to 2 enables holdover
// - tracking enable cleared freezes the tracked control value
// - manual select set drives holdover dac from the manual value
// - manual value 512 gives half-scale control voltage
`timescale 1ns/1ps
`default_nettype none
module pllh_ctl #(
    parameter int ERR_W = 8,
    parameter int DAC_W = 10,
    parameter int CNT_W = 16
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic pd_clk_pin,
    input wire logic [ERR_W-1:0] phase_err_pin,
    input wire logic ref_valid_pin,
    input wire logic [DAC_W-1:0] vtune_code_pin,
    output logic lock_detect_flag,
    output logic holdover_active,
    output logic [DAC_W-1:0] dac_code,
    output logic irq
);

////////////////////////////////////////////////////////////////////////
// pin synchronisers
logic [2:0] pd_sync_r;
logic [ERR_W-1:0] err_m_r, err_s_r;
logic [1:0] ref_sync_r;
logic [DAC_W-1:0] vt_m_r, vt_s_r;
logic pd_tick;
logic ref_valid_s;

always_ff @(posedge mclk)
begin
    pd_sync_r <= {pd_sync_r[1:0], pd_clk_pin};
    err_m_r <= phase_err_pin;
    err_s_r <= err_m_r;
    ref_sync_r <= {ref_sync_r[0], ref_valid_pin};
    vt_m_r <= vtune_code_pin;
    vt_s_r <= vt_m_r;
end

// edge taken between second and third stage only
assign pd_tick = pd_sync_r[1] & ~pd_sync_r[2];
assign ref_valid_s = ref_sync_r[1];

////////////////////////////////////////////////////////////////////////
// bus slave and registers
logic [1:0] mode_r, mode_nxt;
logic track_en_r, track_en_nxt;
logic man_sel_r, man_sel_nxt;
logic inhibit_r, inhibit_nxt;
logic [CNT_W-1:0] thr_r, thr_nxt;
logic [ERR_W-1:0] win_r, win_nxt;
localparam int EV_N_W = pllh_pkg::EV_N;
logic [DAC_W-1:0] manual_dac_value_r, manual_dac_value_nxt;
logic [EV_N_W-1:0] irq_en_r, irq_en_nxt;
logic [EV_N_W-1:0] irq_st_r, irq_st_nxt;
logic [EV_N_W-1:0] ev;
logic wr_pend_r, wr_pend_nxt;
logic [7:0] wr_addr_r, wr_addr_nxt;
logic [31:0] rdata_r, rdata_nxt;
logic addr_ok;

// status and tracked value, owned below
logic lock_r;
logic [DAC_W-1:0] track_r;
pllh_pkg::pllh_state_type st_r;

assign addr_ok = hsel & hready & (htrans == pllh_pkg::HTRANS_NONSEQ);

always_comb
begin
    mode_nxt = mode_r;
    track_en_nxt = track_en_r;
    man_sel_nxt = man_sel_r;
    inhibit_nxt = inhibit_r;
    thr_nxt = thr_r;
    win_nxt = win_r;
    manual_dac_value_nxt = manual_dac_value_r;
    irq_en_nxt = irq_en_r;
    irq_st_nxt = irq_st_r;
    wr_pend_nxt = addr_ok & hwrite;
    wr_addr_nxt = addr_ok ? haddr : wr_addr_r;
    rdata_nxt = rdata_r;
    if (wr_pend_r)
    begin
        unique case (wr_addr_r)
            pllh_pkg::CTRL_OFS:
            begin
                mode_nxt = hwdata[pllh_pkg::CTRL_MODE_LSB +: 2];
                track_en_nxt = hwdata[pllh_pkg::CTRL_TRACK_BIT];
                man_sel_nxt = hwdata[pllh_pkg::CTRL_MANSEL_BIT];
                inhibit_nxt = hwdata[pllh_pkg::CTRL_INHIBIT_BIT];
            end
            pllh_pkg::LOCK_CNT_OFS: thr_nxt = hwdata[CNT_W-1:0];
            pllh_pkg::WINDOW_OFS: win_nxt = hwdata[ERR_W-1:0];
            pllh_pkg::MANUAL_DAC_OFS:
                manual_dac_value_nxt = hwdata[DAC_W-1:0];
            pllh_pkg::IRQ_CLR_OFS:
                irq_st_nxt = irq_st_r & ~hwdata[EV_N_W-1:0];
            pllh_pkg::IRQ_EN_OFS: irq_en_nxt = hwdata[EV_N_W-1:0];
            default: ;
        endcase
    end
    // a new event wins over a clear in the same cycle
    irq_st_nxt = irq_st_nxt | ev;
    if (addr_ok & ~hwrite)
    begin
        rdata_nxt = 32'h0000_0000;
        unique case (haddr)
            pllh_pkg::CTRL_OFS:
            begin
                rdata_nxt[pllh_pkg::CTRL_MODE_LSB +: 2] = mode_r;
                rdata_nxt[pllh_pkg::CTRL_TRACK_BIT] = track_en_r;
                rdata_nxt[pllh_pkg::CTRL_MANSEL_BIT] = man_sel_r;
                rdata_nxt[pllh_pkg::CTRL_INHIBIT_BIT] = inhibit_r;
            end
            pllh_pkg::LOCK_CNT_OFS: rdata_nxt[CNT_W-1:0] = thr_r;
            pllh_pkg::WINDOW_OFS: rdata_nxt[ERR_W-1:0] = win_r;
            pllh_pkg::MANUAL_DAC_OFS:
                rdata_nxt[DAC_W-1:0] = manual_dac_value_r;
            pllh_pkg::STATUS_OFS:
            begin
                rdata_nxt[pllh_pkg::ST_LOCK_BIT] = lock_r;
                rdata_nxt[pllh_pkg::ST_HOLD_BIT] =
                    (st_r == pllh_pkg::ST_HOLDOVER);
                rdata_nxt[pllh_pkg::ST_REF_BIT] = ref_valid_s;
            end
            pllh_pkg::TRACK_OFS: rdata_nxt[DAC_W-1:0] = track_r;
            pllh_pkg::IRQ_STAT_OFS: rdata_nxt[EV_N_W-1:0] = irq_st_r;
            pllh_pkg::IRQ_EN_OFS: rdata_nxt[EV_N_W-1:0] = irq_en_r;
            default: ;
        endcase
    end
end

always_ff @(posedge mclk)
begin
    if (!reset_n)
    begin
        mode_r <= pllh_pkg::MODE_RST;
        track_en_r <= 1'b0;
        man_sel_r <= 1'b0;
        inhibit_r <= 1'b0;
        thr_r <= pllh_pkg::LOCK_CNT_RST;
        win_r <= pllh_pkg::WINDOW_RST;
        manual_dac_value_r <= pllh_pkg::MANUAL_DAC_RST;
        irq_en_r <= '0;
        irq_st_r <= '0;
        wr_pend_r <= 1'b0;
        wr_addr_r <= 8'h00;
        rdata_r <= 32'h0000_0000;
        hreadyout <= 1'b0;
        hresp <= 1'b0;
        irq <= 1'b0;
    end
    else
    begin
        mode_r <= mode_nxt;
        track_en_r <= track_en_nxt;
        man_sel_r <= man_sel_nxt;
        inhibit_r <= inhibit_nxt;
        thr_r <= thr_nxt;
        win_r <= win_nxt;
        manual_dac_value_r <= manual_dac_value_nxt;
        irq_en_r <= irq_en_nxt;
        irq_st_r <= irq_st_nxt;
        wr_pend_r <= wr_pend_nxt;
        wr_addr_r <= wr_addr_nxt;
        rdata_r <= rdata_nxt;
        // zero wait states, always okay
        hreadyout <= 1'b1;
        hresp <= 1'b0;
        irq <= |(irq_st_nxt & irq_en_nxt);
    end
end

assign hrdata = rdata_r;

////////////////////////////////////////////////////////////////////////
// lock detector
logic [CNT_W-1:0] cnt_r, cnt_nxt;
logic lock_nxt;
logic in_win;

assign in_win = (err_s_r <= win_r);

always_comb
begin
    cnt_nxt = cnt_r;
    lock_nxt = lock_r;
    if (pd_tick)
    begin
        if (in_win)
        begin
            // saturate so a long lock never wraps
            if (cnt_r < thr_r)
                cnt_nxt = cnt_r + 1'b1;
            if (cnt_nxt >= thr_r)
                lock_nxt = 1'b1;
        end
        else
        begin
            cnt_nxt = '0;
            lock_nxt = 1'b0;
        end
    end
end

always_ff @(posedge mclk)
begin
    if (!reset_n)
    begin
        cnt_r <= '0;
        lock_r <= 1'b0;
    end
    else
    begin
        cnt_r <= cnt_nxt;
        lock_r <= lock_nxt;
    end
end

////////////////////////////////////////////////////////////////////////
// holdover controller
pllh_pkg::pllh_state_type st_nxt;
logic [DAC_W-1:0] track_nxt, dac_nxt;
logic lock_lost;

assign lock_lost = lock_r & ~lock_nxt;

always_comb
begin
    st_nxt = st_r;
    unique case (st_r)
        pllh_pkg::ST_LOCKING:
            // no holdover on power-up, only on a lost lock
            if ((mode_r == pllh_pkg::HO_MODE_EN) && !inhibit_r
                && lock_lost)
                st_nxt = pllh_pkg::ST_HOLDOVER;
        pllh_pkg::ST_HOLDOVER:
            // a small threshold makes this chatter
            if (ref_valid_s || mode_r != pllh_pkg::HO_MODE_EN)
                st_nxt = pllh_pkg::ST_LOCKING;
    endcase
    track_nxt = track_r;
    if (track_en_r && st_r == pllh_pkg::ST_LOCKING)
        track_nxt = vt_s_r;
    if (st_r == pllh_pkg::ST_HOLDOVER)
        dac_nxt = man_sel_r ? manual_dac_value_r : track_r;
    else
        dac_nxt = track_r;
end

assign ev[pllh_pkg::EV_LOCK_GAIN] = ~lock_r & lock_nxt;
assign ev[pllh_pkg::EV_LOCK_LOSS] = lock_lost;
assign ev[pllh_pkg::EV_HO_ENTER] = (st_r == pllh_pkg::ST_LOCKING)
    && (st_nxt == pllh_pkg::ST_HOLDOVER);
assign ev[pllh_pkg::EV_HO_EXIT] = (st_r == pllh_pkg::ST_HOLDOVER)
    && (st_nxt == pllh_pkg::ST_LOCKING);

always_ff @(posedge mclk)
begin
    if (!reset_n)
    begin
        st_r <= pllh_pkg::ST_LOCKING;
        track_r <= pllh_pkg::TRACK_RST;
        dac_code <= pllh_pkg::TRACK_RST;
        lock_detect_flag <= 1'b0;
        holdover_active <= 1'b0;
    end
    else
    begin
        st_r <= st_nxt;
        track_r <= track_nxt;
        dac_code <= dac_nxt;
        lock_detect_flag <= lock_nxt;
        holdover_active <= (st_nxt == pllh_pkg::ST_HOLDOVER);
    end
end

////////////////////////////////////////////////////////////////////////
// assertions
default clocking cb @(posedge mclk); endclocking
default disable iff (!reset_n);

sequence s_win_tick;
    pd_tick && in_win;
endsequence

property p_lock_rise;
    s_win_tick ##0 (cnt_r + 1'b1 == thr_r) |=> lock_r ##0 lock_detect_flag;
endproperty
a_lock_rise: assert property (p_lock_rise)
    else $error("lock flag did not rise at threshold");

property p_lock_time;
    $rose(lock_r) |-> (cnt_r >= thr_r) && $past(pd_tick);
endproperty
a_lock_time: assert property (p_lock_time)
    else $error("lock declared before threshold reached");

property p_lock_fall;
    pd_tick && !in_win |=> !lock_r && !lock_detect_flag && cnt_r == 0;
endproperty
a_lock_fall: assert property (p_lock_fall)
    else $error("lock flag or count kept after window exceeded");

property p_cnt_inc;
    s_win_tick ##0 (cnt_r < thr_r) |=> cnt_r == $past(cnt_r) + 1'b1;
endproperty
a_cnt_inc: assert property (p_cnt_inc)
    else $error("in-window count did not advance");

property p_ho_enter;
    st_r == pllh_pkg::ST_LOCKING && mode_r == pllh_pkg::HO_MODE_EN
        && !inhibit_r && lock_lost
        |=> holdover_active && irq_st_r[pllh_pkg::EV_HO_ENTER];
endproperty
a_ho_enter: assert property (p_ho_enter)
    else $error("lock loss did not start holdover");

property p_ho_exit;
    st_r == pllh_pkg::ST_HOLDOVER && ref_valid_s
        |=> !holdover_active && st_r == pllh_pkg::ST_LOCKING;
endproperty
a_ho_exit: assert property (p_ho_exit)
    else $error("valid reference did not end holdover");

property p_mode_off;
    mode_r != pllh_pkg::HO_MODE_EN |=> !holdover_active;
endproperty
a_mode_off: assert property (p_mode_off)
    else $error("holdover active while mode not enabled");

property p_track_hold;
    !track_en_r |=> track_r == $past(track_r);
endproperty
a_track_hold: assert property (p_track_hold)
    else $error("tracked value moved with tracking off");

property p_manual_dac;
    st_r == pllh_pkg::ST_HOLDOVER && man_sel_r
        |=> dac_code == $past(manual_dac_value_r);
endproperty
a_manual_dac: assert property (p_manual_dac)
    else $error("holdover dac not from manual value");

property p_half_scale;
    st_r == pllh_pkg::ST_HOLDOVER && man_sel_r
        && manual_dac_value_r == pllh_pkg::MANUAL_DAC_RST
        |=> dac_code[DAC_W-1] && ~|dac_code[DAC_W-2:0];
endproperty
a_half_scale: assert property (p_half_scale)
    else $error("manual value 512 did not give half-scale dac");

endmodule : pllh_ctl
`default_nettype wire

// File: testbench/testbench.sv
// self-checking bench for the lock detector and holdover controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
logic mclk = 1'b0;
logic reset_n, hsel, hwrite, pd_clk_pin, ref_valid_pin;
logic [7:0] haddr, phase_err_pin;
logic [1:0] htrans;
logic [2:0] hsize;
logic [31:0] hwdata, hrdata;
logic [9:0] vtune_code_pin, dac_code, vt, md;
logic hreadyout, hresp, lock_detect_flag, holdover_active, irq;
wire logic hready;
logic rd_pend = 1'b0;
logic [31:0] exp_q[$], pin_q[$];
int n_errors = 0;
int n_compared = 0;
event snap;
assign hready = hreadyout;
always #12.5 mclk = ~mclk;
pllh_ctl uut (.mclk(mclk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .pd_clk_pin(pd_clk_pin), .phase_err_pin(phase_err_pin),
    .ref_valid_pin(ref_valid_pin), .vtune_code_pin(vtune_code_pin),
    .lock_detect_flag(lock_detect_flag), .holdover_active(holdover_active),
    .dac_code(dac_code), .irq(irq));
////////////////////////////////////////////////////////////////////////////
task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
        n_errors++;
        $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
endtask : check
task automatic print_verdict();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
        $display("Finished cleanly");
    else
        $display("Finished with errors");
    $finish;
endtask : print_verdict
// master waits on hready, no cycle count assumed
task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= pllh_pkg::HTRANS_NONSEQ;
    do @(posedge mclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hready !== 1'b1);
endtask : bus
task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(a, 1'b0, 32'h0);
endtask : rd
task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
endtask : wr
task automatic pk(input logic l, input logic h, input logic [9:0] d,
    input logic i);
    pin_q.push_back({19'h0, l, h, d, i});
    @(posedge mclk);
    @(negedge mclk);
    -> snap;
    @(posedge mclk);
endtask : pk
// error held well before and after the detector edge
task automatic tick(input logic [7:0] e);
    phase_err_pin <= e;
    repeat (4) @(posedge mclk);
    pd_clk_pin <= 1'b1;
    repeat (3) @(posedge mclk);
    pd_clk_pin <= 1'b0;
    repeat (4) @(posedge mclk);
endtask : tick
task automatic relock();
    tick(8'($urandom_range(4)));
    tick(8'h04);
    tick(8'($urandom_range(4)));
    tick(8'h05);
endtask : relock
////////////////////////////////////////////////////////////////////////////
always @(posedge mclk)
begin
    if (rd_pend && hready === 1'b1)
    begin
        check(hrdata, exp_q.pop_front());
        check({31'h0, hresp}, 32'h0);
    end
    if (hready === 1'b1)
        rd_pend <= hsel && htrans == pllh_pkg::HTRANS_NONSEQ && !hwrite;
end
always @(snap)
    check({19'h0, lock_detect_flag, holdover_active, dac_code, irq},
        pin_q.pop_front());
initial
begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    print_verdict();
end
////////////////////////////////////////////////////////////////////////////
initial
begin
    reset_n = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    pd_clk_pin = 1'b0;
    phase_err_pin = 8'h00;
    ref_valid_pin = 1'b0;
    vtune_code_pin = 10'h200;
    void'($urandom(32'hd6a847e8));
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    pk(1'b0, 1'b0, 10'h200, 1'b0);
    rd(pllh_pkg::CTRL_OFS, 32'h0);
    rd(pllh_pkg::LOCK_CNT_OFS, 32'h2710);
    rd(pllh_pkg::WINDOW_OFS, 32'h4);
    rd(pllh_pkg::MANUAL_DAC_OFS, 32'h200);
    rd(pllh_pkg::IRQ_EN_OFS, 32'h0);
    rd(8'h24, 32'h0);
    wr(pllh_pkg::STATUS_OFS, 32'hffffffff);
    rd(pllh_pkg::STATUS_OFS, 32'h0);
    // count of three keeps lock time short
    vt = 10'($urandom_range(1023));
    vtune_code_pin <= vt;
    ref_valid_pin <= 1'b1;
    wr(pllh_pkg::LOCK_CNT_OFS, 32'h3);
    wr(pllh_pkg::CTRL_OFS, 32'h6);
    repeat (6) @(posedge mclk);
    rd(pllh_pkg::TRACK_OFS, {22'h0, vt});
    relock();
    // small count: loss enters holdover, valid reference exits at once
    rd(pllh_pkg::IRQ_STAT_OFS, 32'hf);
    wr(pllh_pkg::IRQ_CLR_OFS, 32'hf);
    tick(8'h04);
    tick(8'($urandom_range(4)));
    rd(pllh_pkg::STATUS_OFS, 32'h4);
    tick(8'h00);
    rd(pllh_pkg::STATUS_OFS, 32'h5);
    ref_valid_pin <= 1'b0;
    repeat (6) @(posedge mclk);
    tick(8'hff);
    rd(pllh_pkg::STATUS_OFS, 32'h2);
    vtune_code_pin <= ~vt;
    pk(1'b0, 1'b1, vt, 1'b0);
    wr(pllh_pkg::CTRL_OFS, 32'he);
    pk(1'b0, 1'b1, 10'h200, 1'b0);
    md = 10'($urandom_range(1023));
    wr(pllh_pkg::MANUAL_DAC_OFS, {22'h0, md});
    pk(1'b0, 1'b1, md, 1'b0);
    rd(pllh_pkg::IRQ_STAT_OFS, 32'h7);
    wr(pllh_pkg::IRQ_EN_OFS, 32'h8);
    pk(1'b0, 1'b1, md, 1'b0);
    wr(pllh_pkg::IRQ_EN_OFS, 32'h4);
    pk(1'b0, 1'b1, md, 1'b1);
    wr(pllh_pkg::IRQ_CLR_OFS, 32'h4);
    pk(1'b0, 1'b1, md, 1'b0);
    rd(pllh_pkg::IRQ_STAT_OFS, 32'h3);
    wr(pllh_pkg::IRQ_CLR_OFS, 32'hf);
    ref_valid_pin <= 1'b1;
    repeat (6) @(posedge mclk);
    pk(1'b0, 1'b0, ~vt, 1'b0);
    rd(pllh_pkg::IRQ_STAT_OFS, 32'h8);
    wr(pllh_pkg::CTRL_OFS, 32'h2);
    vtune_code_pin <= vt;
    repeat (6) @(posedge mclk);
    rd(pllh_pkg::TRACK_OFS, {22'h0, ~vt});
    // inhibit set: loss must not start holdover
    ref_valid_pin <= 1'b0;
    wr(pllh_pkg::CTRL_OFS, 32'h12);
    relock();
    tick(8'h01);
    tick(8'h80);
    rd(pllh_pkg::STATUS_OFS, 32'h0);
    for (int m = 0; m < 4; m++)
    begin
        wr(pllh_pkg::CTRL_OFS, 32'(m));
        relock();
        tick(8'h02);
        tick(8'h40);
        rd(pllh_pkg::STATUS_OFS, (m == 2) ? 32'h2 : 32'h0);
    end
    print_verdict();
end
endmodule : testbench
`default_nettype wire
